// File: inc/lcr_map.vh
`ifndef LCR_MAP_VH
`define LCR_MAP_VH

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LCR_RST_DISPLAY_ENABLE   1'h0
`define LCR_RST_FIRST_ROW        6'h00
`define LCR_RST_PAGE             3'h7
`define LCR_RST_COLUMN           7'h00
`define LCR_RST_LOW_POWER        1'h0
`define LCR_RST_DUTY             1'h1
`define LCR_RST_SEG_ORDER        1'h0
`define LCR_RST_FLAGS            4'h0

// ----------------------------------------------------------------
// Command encodings (upper bits compared, low bits carry the value)
// ----------------------------------------------------------------
`define LCR_CMD_DISPLAY          7'h57
`define LCR_CMD_START_LINE       3'h6
`define LCR_CMD_PAGE             6'h2e
`define LCR_CMD_SEG_ORDER        7'h50
`define LCR_CMD_LOW_POWER        7'h52
`define LCR_CMD_DUTY             7'h54
`define LCR_COLUMN_LAST          7'h4f

// ----------------------------------------------------------------
// Status byte bit positions
// ----------------------------------------------------------------
`define LCR_ST_BUSY              7
`define LCR_ST_SEG_ORDER         6
`define LCR_ST_DISPLAY_OFF       5
`define LCR_ST_RESETTING         4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LCR_CLK_NS               5
`define LCR_BUSY_NS              100
`define LCR_RESET_BUSY_NS        1000
`define LCR_BUSY_CYC             ((`LCR_BUSY_NS + `LCR_CLK_NS - 1) / `LCR_CLK_NS)
`define LCR_RESET_BUSY_CYC       ((`LCR_RESET_BUSY_NS + `LCR_CLK_NS - 1) / `LCR_CLK_NS)

`endif

// File: design/lcr_sync.v
`timescale 1ns/10ps

module lcr_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input  wire             clk_sys,
    input  wire             rstn,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    // ------------------------------------------------------------
    // Two-stage synchroniser; the first stage feeds only the second
    // ------------------------------------------------------------
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    always @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            meta_q <= INIT;
            sync_q <= INIT;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule

// File: design/lcr_row_map.v
`timescale 1ns/10ps

module lcr_row_map (
    input  wire [5:0] first_row,
    input  wire       duty_full,
    input  wire [4:0] com_index,
    output wire [4:0] mem_row
);

    // ------------------------------------------------------------
    // Row routed to a common line, wrapping on the active duty
    // ------------------------------------------------------------
    wire [4:0] sum;

    assign sum     = first_row[4:0] + com_index;
    assign mem_row = duty_full ? sum : {1'b0, sum[3:0]};

endmodule

// File: design/lcr_core.v
`timescale 1ns/10ps
`include "lcr_map.vh"

// Operation
// - Display enable bit, reset zero
// - Six-bit first row pointer, reset zero
// - Three-bit page pointer, reset all ones
// - Seven-bit column pointer, reset zero
// - Low power hold bit, reset zero
// - Duty choice bit, reset one
// - Segment order bit, reset normal
// - Four status flags, zero after reset
// - Enable one drives panel from memory
// - Enable zero blanks all outputs high
// - Display command AF on, AE off
// - Half selects enable left/right segments
// - Busy shown on top bus line
// - Bus driven only during read cycles
// - First row pointer maps rows, wrapping
module lcr_core #(
    parameter BUSY_CYC       = `LCR_BUSY_CYC,
    parameter RESET_BUSY_CYC = `LCR_RESET_BUSY_CYC
) (
    input  wire       clk_sys,
    input  wire       rstn,
    input  wire       cmd_data_pin,
    input  wire       strobe_pin,
    input  wire       read_write_pin,
    input  wire       left_half_select,
    input  wire       right_half_select,
    input  wire [7:0] host_bus_lines_i,
    output wire [7:0] host_bus_lines_o,
    output wire       host_bus_lines_oe_n,
    input  wire [4:0] com_index,
    output wire [4:0] com_mem_row,
    output wire       display_enable,
    output wire       panel_blank,
    output wire [5:0] first_row_pointer,
    output wire [2:0] page_pointer,
    output wire [6:0] column_pointer,
    output wire       low_power_hold,
    output wire       duty_choice,
    output wire       segment_order,
    output wire       left_half_active,
    output wire       right_half_active,
    output wire       busy
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    wire [4:0] ctl_s;
    wire [7:0] bus_s;
    wire       cd_s;
    wire       strobe_s;
    wire       rw_s;
    wire       cs1_s;
    wire       cs2_s;

    // Control and data pass the same two stages, so a byte and its
    // qualifiers always reach the core in the same cycle.
    lcr_sync #(
        .WIDTH (5),
        .INIT  (5'h00)
    ) u_sync_ctl (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .async_in ({cmd_data_pin, strobe_pin, read_write_pin, left_half_select, right_half_select}),
        .sync_out (ctl_s)
    );

    lcr_sync #(
        .WIDTH (8),
        .INIT  (8'h00)
    ) u_sync_bus (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .async_in (host_bus_lines_i),
        .sync_out (bus_s)
    );

    assign cd_s     = ctl_s[4];
    assign strobe_s = ctl_s[3];
    assign rw_s     = ctl_s[2];
    assign cs1_s    = ctl_s[1];
    assign cs2_s    = ctl_s[0];

    // ------------------------------------------------------------
    // Strobe edge and cycle capture
    // ------------------------------------------------------------
    // Data hold after the strobe falls is short, so bus and control
    // are latched throughout the high phase and used at the fall.
    // Qualifiers reset to read and data so that no stray write can
    // fire before the first real strobe.
    reg        strobe_q;
    reg  [7:0] cap_data_q;
    reg        cap_cd_q;
    reg        cap_rw_q;
    reg        cap_sel_q;
    wire       selected;
    wire       strobe_fall;
    wire       cmd_write;

    assign selected    = cs1_s | cs2_s;
    assign strobe_fall = strobe_q & ~strobe_s;
    assign cmd_write   = strobe_fall & cap_sel_q & ~cap_cd_q & ~cap_rw_q;

    always @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            strobe_q   <= 1'b0;
            cap_data_q <= 8'h00;
            cap_cd_q   <= 1'b1;
            cap_rw_q   <= 1'b1;
            cap_sel_q  <= 1'b0;
        end
        else
        begin
            strobe_q <= strobe_s;
            if (strobe_s)
            begin
                cap_data_q <= bus_s;
                cap_cd_q   <= cd_s;
                cap_rw_q   <= rw_s;
                cap_sel_q  <= selected;
            end
        end
    end

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    // Start line and page keep their top bit at zero; only the low
    // bits of the command byte reach them. Column values past the
    // last column are dropped, not wrapped.
    wire hit_display;
    wire hit_start;
    wire hit_page;
    wire hit_column;
    wire hit_seg;
    wire hit_power;
    wire hit_duty;

    assign hit_display = cmd_write & (cap_data_q[7:1] == `LCR_CMD_DISPLAY);
    assign hit_start   = cmd_write & (cap_data_q[7:5] == `LCR_CMD_START_LINE);
    assign hit_page    = cmd_write & (cap_data_q[7:2] == `LCR_CMD_PAGE);
    assign hit_column  = cmd_write & ~cap_data_q[7] & (cap_data_q[6:0] <= `LCR_COLUMN_LAST);
    assign hit_seg     = cmd_write & (cap_data_q[7:1] == `LCR_CMD_SEG_ORDER);
    assign hit_power   = cmd_write & (cap_data_q[7:1] == `LCR_CMD_LOW_POWER);
    assign hit_duty    = cmd_write & (cap_data_q[7:1] == `LCR_CMD_DUTY);

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Any byte that hits no decode leaves every register untouched.
    // A later command simply overwrites; nothing is queued.
    reg       display_enable_q;
    reg [5:0] first_row_q;
    reg [2:0] page_q;
    reg [6:0] column_q;
    reg       low_power_q;
    reg       duty_q;
    reg       seg_order_q;

    always @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            display_enable_q <= `LCR_RST_DISPLAY_ENABLE;
            first_row_q      <= `LCR_RST_FIRST_ROW;
            page_q           <= `LCR_RST_PAGE;
            column_q         <= `LCR_RST_COLUMN;
            low_power_q      <= `LCR_RST_LOW_POWER;
            duty_q           <= `LCR_RST_DUTY;
            seg_order_q      <= `LCR_RST_SEG_ORDER;
        end
        else
        begin
            if (hit_display)
                display_enable_q <= cap_data_q[0];
            if (hit_start)
                first_row_q <= {1'b0, cap_data_q[4:0]};
            if (hit_page)
                page_q <= {1'b0, cap_data_q[1:0]};
            if (hit_column)
                column_q <= cap_data_q[6:0];
            if (hit_seg)
                seg_order_q <= cap_data_q[0];
            if (hit_power)
                low_power_q <= cap_data_q[0];
            if (hit_duty)
                duty_q <= cap_data_q[0];
        end
    end

    // ------------------------------------------------------------
    // Busy and reset-in-progress timing
    // ------------------------------------------------------------
    // A command arriving while busy is still taken; busy restarts.
    // Sixteen bits leave room for a faster clock than the default, and
    // every reset, a mid-run one too, reloads the reset-busy count.
    reg [15:0] busy_cnt_q;
    reg [15:0] reset_cnt_q;

    always @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            busy_cnt_q  <= 16'h0000;
            reset_cnt_q <= RESET_BUSY_CYC[15:0];
        end
        else
        begin
            if (cmd_write)
                busy_cnt_q <= BUSY_CYC[15:0];
            else if (busy_cnt_q != 16'h0000)
                busy_cnt_q <= busy_cnt_q - 16'h0001;
            if (reset_cnt_q != 16'h0000)
                reset_cnt_q <= reset_cnt_q - 16'h0001;
        end
    end

    wire resetting;
    wire busy_now;

    assign resetting = (reset_cnt_q != 16'h0000);
    assign busy_now  = (busy_cnt_q != 16'h0000) | resetting;

    // ------------------------------------------------------------
    // Status flags and read drive
    // ------------------------------------------------------------
    reg  [3:0] flags_q;
    reg  [7:0] rd_data_q;
    reg        oe_n_q;
    wire       read_cycle;
    wire [7:0] status_byte;

    // Flags mirror live state one cycle late and are never sticky,
    // so no set can race a clear. Data reads return zero, as no
    // display memory sits behind this core.
    assign read_cycle  = strobe_s & rw_s & selected;

    always @(posedge clk_sys)
    begin
        if (!rstn)
            flags_q <= `LCR_RST_FLAGS;
        else
            flags_q <= {busy_now, seg_order_q, ~display_enable_q, resetting};
    end

    assign status_byte = {flags_q, 4'h0};

    always @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            rd_data_q <= 8'h00;
            oe_n_q    <= 1'b1;
        end
        else
        begin
            oe_n_q <= ~read_cycle;
            if (read_cycle && !cd_s)
                rd_data_q <= status_byte;
            else
                rd_data_q <= 8'h00;
        end
    end

    assign host_bus_lines_o    = rd_data_q;
    assign host_bus_lines_oe_n = oe_n_q;

    // ------------------------------------------------------------
    // Panel side
    // ------------------------------------------------------------
    // Blanking overrides memory data further down the panel path;
    // the half selects leave here already synchronised.
    lcr_row_map u_row_map (
        .first_row (first_row_q),
        .duty_full (duty_q),
        .com_index (com_index),
        .mem_row   (com_mem_row)
    );

    assign display_enable    = display_enable_q;
    assign panel_blank       = ~display_enable_q;
    assign first_row_pointer = first_row_q;
    assign page_pointer      = page_q;
    assign column_pointer    = column_q;
    assign low_power_hold    = low_power_q;
    assign duty_choice       = duty_q;
    assign segment_order     = seg_order_q;
    assign left_half_active  = cs1_s;
    assign right_half_active = cs2_s;
    assign busy              = flags_q[3];

endmodule

// File: tb/lcr_chk_properties.sv
`timescale 1ns/10ps
module lcr_chk #(
    parameter BUSY_CYC       = 4,
    parameter RESET_BUSY_CYC = 8
) (
    input wire       clk_sys,
    input wire       rstn,
    input wire       cmd_data_pin,
    input wire       strobe_pin,
    input wire       read_write_pin,
    input wire       left_half_select,
    input wire       right_half_select,
    input wire [7:0] host_bus_lines_o,
    input wire       host_bus_lines_oe_n,
    input wire [4:0] com_index,
    input wire [4:0] com_mem_row,
    input wire       display_enable,
    input wire       panel_blank,
    input wire [5:0] first_row_pointer,
    input wire [2:0] page_pointer,
    input wire [6:0] column_pointer,
    input wire       low_power_hold,
    input wire       duty_choice,
    input wire       segment_order,
    input wire       left_half_active,
    input wire       right_half_active,
    input wire       busy
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    property p_rst;
        $rose(rstn) |-> !display_enable && first_row_pointer == 6'h00 && page_pointer == 3'h7
            && column_pointer == 7'h00 && !low_power_hold && duty_choice && !segment_order;
    endproperty
    a_rst: assert property (p_rst) else $error("bad register value after reset");
    property p_blank;
        panel_blank == !display_enable;
    endproperty
    a_blank: assert property (p_blank) else $error("blank output disagrees with enable");
    property p_drive;
        $fell(host_bus_lines_oe_n) |-> $past(strobe_pin, 2) && $past(read_write_pin, 2);
    endproperty
    a_drive: assert property (p_drive) else $error("bus driven outside a read");
    property p_rel;
        $fell(strobe_pin) && !host_bus_lines_oe_n |-> ##[1:4] host_bus_lines_oe_n;
    endproperty
    a_rel: assert property (p_rel) else $error("bus not released after read");
    property p_low;
        !host_bus_lines_oe_n |-> host_bus_lines_o[3:0] == 4'h0;
    endproperty
    a_low: assert property (p_low) else $error("unused status bits set");
    property p_st;
        !host_bus_lines_oe_n && !$past(cmd_data_pin, 3)
            |-> host_bus_lines_o[6:5] == $past({segment_order, ~display_enable}, 2);
    endproperty
    a_st: assert property (p_st) else $error("status bits disagree with state");
    property p_busy;
        !host_bus_lines_oe_n && !$past(cmd_data_pin, 3) |-> host_bus_lines_o[7] == $past(busy);
    endproperty
    a_busy: assert property (p_busy) else $error("busy missing from top bus line");
    property p_cmd;
        $changed(column_pointer) || $changed(page_pointer) || $changed(first_row_pointer)
            |-> !$past(strobe_pin, 1) && !$past(strobe_pin, 2);
    endproperty
    a_cmd: assert property (p_cmd) else $error("register moved before strobe fell");
    property p_sel;
        $rose(left_half_select) |-> ##[1:3] left_half_active;
    endproperty
    a_sel: assert property (p_sel) else $error("left half not enabled");
    property p_sel_r;
        $rose(right_half_select) |-> ##[1:3] right_half_active;
    endproperty
    a_sel_r: assert property (p_sel_r) else $error("right half not enabled");
    property p_row;
        com_mem_row == (duty_choice ? 5'(first_row_pointer[4:0] + com_index)
            : {1'b0, 4'(first_row_pointer[3:0] + com_index[3:0])});
    endproperty
    a_row: assert property (p_row) else $error("row mapping wrong");
    c_read: cover property (!host_bus_lines_oe_n && host_bus_lines_o[7]);
    c_on: cover property ($rose(display_enable));
    c_row: cover property ($changed(first_row_pointer) && !duty_choice);
endmodule

bind lcr_core lcr_chk #(.BUSY_CYC(BUSY_CYC), .RESET_BUSY_CYC(RESET_BUSY_CYC)) i_lcr_chk (
    .clk_sys, .rstn, .cmd_data_pin, .strobe_pin, .read_write_pin, .left_half_select, .host_bus_lines_o,
    .host_bus_lines_oe_n, .com_index, .com_mem_row, .display_enable, .panel_blank, .first_row_pointer,
    .page_pointer, .column_pointer, .low_power_hold, .duty_choice, .segment_order, .left_half_active, .busy,
    .right_half_select, .right_half_active);

// File: tb/lcr_host.sv
`timescale 1ns/10ps
module lcr_host (
    input  wire        clk_sys,
    input  wire  [7:0] host_bus_lines_o,
    input  wire        host_bus_lines_oe_n,
    output logic       cmd_data_pin,
    output logic       strobe_pin,
    output logic       read_write_pin,
    output logic       left_half_select,
    output logic       right_half_select,
    output logic [7:0] host_bus_lines_i
);
    initial
    begin
        {cmd_data_pin, strobe_pin, read_write_pin} = 3'h5;
        {left_half_select, right_half_select} = 2'h0;
        host_bus_lines_i = 8'h5a;
    end
    // ----------------
    // Command write
    // ----------------
    task automatic wr(input logic [7:0] c, input logic [1:0] s);
        @(negedge clk_sys);
        {left_half_select, right_half_select} = s;
        {cmd_data_pin, read_write_pin, strobe_pin} = 3'h1;
        host_bus_lines_i = c;
        repeat (4) @(negedge clk_sys);
        strobe_pin = 1'b0;
        repeat (2) @(negedge clk_sys);
        {cmd_data_pin, read_write_pin} = 2'h3;
        // Released bus shows the inverse so a stale byte cannot pass
        host_bus_lines_i = ~c;
        {left_half_select, right_half_select} = 2'h0;
    endtask
    // ----------------
    // Status read
    // ----------------
    task automatic rd(output logic [7:0] v);
        int n;
        @(negedge clk_sys);
        {left_half_select, cmd_data_pin, read_write_pin, strobe_pin} = 4'hb;
        // Look on falling edges, where the registered bus has settled
        for (n = 0; n < 8; n++)
        begin
            @(negedge clk_sys);
            if (host_bus_lines_oe_n === 1'b0) break;
        end
        v = host_bus_lines_o;
        @(negedge clk_sys);
        {left_half_select, strobe_pin} = 2'h0;
        repeat (4) @(negedge clk_sys);
    endtask
endmodule

// File: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic       clk_sys, rstn;
    logic [4:0] com_index;
    logic [7:0] b, st;
    logic [7:0] codes [17] = '{8'hAF, 8'hAE, 8'hA0, 8'hA1, 8'hA5, 8'hA4, 8'hA8, 8'hA9, 8'hDF, 8'hC0,
                               8'hBB, 8'hB8, 8'h4F, 8'h50, 8'h7F, 8'hE0, 8'hAF};
    wire        cmd_data_pin, strobe_pin, read_write_pin, left_half_select, right_half_select;
    wire        host_bus_lines_oe_n, display_enable, panel_blank, low_power_hold, duty_choice;
    wire        segment_order, left_half_active, right_half_active, busy;
    wire  [7:0] host_bus_lines_i, host_bus_lines_o;
    wire  [4:0] com_mem_row;
    wire  [5:0] first_row_pointer;
    wire  [2:0] page_pointer;
    wire  [6:0] column_pointer;
    int         err_count, check_count, cyc, k;
    int         m [7];
    lcr_core #(.BUSY_CYC(4), .RESET_BUSY_CYC(8)) i_lcr_core (.clk_sys, .rstn, .cmd_data_pin, .strobe_pin,
        .read_write_pin, .left_half_select, .right_half_select, .host_bus_lines_i, .host_bus_lines_o,
        .host_bus_lines_oe_n, .com_index, .com_mem_row, .display_enable, .panel_blank, .first_row_pointer,
        .page_pointer, .column_pointer, .low_power_hold, .duty_choice, .segment_order, .left_half_active,
        .right_half_active, .busy);
    lcr_host i_lcr_host (.clk_sys, .host_bus_lines_o, .host_bus_lines_oe_n, .cmd_data_pin, .strobe_pin,
        .read_write_pin, .left_half_select, .right_half_select, .host_bus_lines_i);
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            final_report;
        end
    end
    // ----------------
    // Checks and model
    // ----------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        if (got !== exp)
            err_count++;
    endtask
    task automatic cmp_all;
        chk(display_enable, m[0]);
        chk(panel_blank, !m[0]);
        chk(first_row_pointer, m[1]);
        chk(page_pointer, m[2]);
        chk(column_pointer, m[3]);
        chk(low_power_hold, m[4]);
        chk(duty_choice, m[5]);
        chk(segment_order, m[6]);
        chk(com_mem_row, (m[1] + com_index) % (m[5] ? 32 : 16));
    endtask
    task automatic rd_chk;
        i_lcr_host.rd(st);
        chk(st, m[6] * 64 + (m[0] ? 0 : 32));
        chk(host_bus_lines_oe_n, 1);
    endtask
    task automatic step(input logic [7:0] c, input logic [1:0] s);
        i_lcr_host.wr(c, s);
        // A write with neither half selected must change nothing
        if (s == 2'h0) ;
        else if (c[7:1] == 7'h57) m[0] = c[0];
        else if (c[7:5] == 3'h6) m[1] = c[4:0];
        else if (c[7:2] == 6'h2e) m[2] = c[1:0];
        else if (c < 8'h50) m[3] = c;
        else if (c[7:1] == 7'h50) m[6] = c[0];
        else if (c[7:1] == 7'h52) m[4] = c[0];
        else if (c[7:1] == 7'h54) m[5] = c[0];
        repeat (8) @(negedge clk_sys);
        cmp_all;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        rstn = 1'b0;
        com_index = 5'h00;
        m = '{0, 0, 7, 0, 0, 1, 0};
        b = $urandom(32'h4901_12a2);
        repeat (5) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (20) @(negedge clk_sys);
        cmp_all;
        rd_chk;
        $display("test reset values done");
        for (k = 0; k < 17; k++)
        begin
            step(codes[k], k[1:0] + 2'h1);
            rd_chk;
        end
        $display("test command table done");
        i_lcr_host.wr(8'hAE, 2'h3);
        repeat (2) @(negedge clk_sys);
        i_lcr_host.rd(st);
        chk(st[7], 1);
        m[0] = 0;
        $display("test busy readback done");
        for (k = 0; k < 150; k++)
        begin
            com_index = $urandom;
            step($urandom, $urandom);
        end
        $display("test random commands done");
        rstn = 1'b0;
        repeat (5) @(negedge clk_sys);
        rstn = 1'b1;
        m = '{0, 0, 7, 0, 0, 1, 0};
        repeat (20) @(negedge clk_sys);
        cmp_all;
        step(8'hAF, 2'h2);
        $display("test second reset done");
        final_report;
    end
endmodule
